// *** common/ep_ctrl_regs.svh ***
/*
 * register indices, field positions and reset values of the endpoint
 * control register file; included by the design and the assertion files.
 */
// Functional notes
// - OUT endpoints 1-3 interrupt enables, reset enabled
// - IN endpoints 1-3 interrupt enables, reset enabled
// - endpoint 0 interrupt enable, reset enabled
// - common enables frame/reset/resume/suspend, resets 0110
// - seven-bit endpoint 0 received byte count
// - disabled endpoint sends no handshake at all
// - send stall answers IN with STALL, not isochronous
// - transfer type bit: bulk/interrupt or isochronous
// - direction bit OUT/IN, ignored when FIFO split
// - access through index then data register
// - reading common flags clears the returned flags
`ifndef EP_CTRL_REGS_SVH
`define EP_CTRL_REGS_SVH

`define IDX_IN_FLAGS 8'h02
`define IDX_OUT_FLAGS 8'h04
`define IDX_CM_FLAGS 8'h06
`define IDX_IN_IE 8'h07
`define IDX_OUT_IE 8'h09
`define IDX_CM_IE 8'h0b
`define IDX_EP_SEL 8'h0e
`define IDX_CSR_LOW 8'h11
`define IDX_CSR_HIGH 8'h12
`define IDX_E0_COUNT 8'h16
`define IDX_EP_ENABLE 8'h1e

`define RST_IN_IE 4'hf
`define RST_OUT_IE 3'h7
`define RST_CM_IE 4'h6
`define RST_EP_ENABLE 8'h1f
`define MASK_EP_ENABLE 8'h0f
`define MASK_CSR_HIGH 8'hec

// ep0 control/status bits
`define B_SERVICED_SETUP_END 7
`define B_SERVICED_RX_PACKET 6
`define B_SEND_STALL 5
`define B_SETUP_END_FLAG 4
`define B_CONTROL_DATA_END 3
`define B_STALL_SENT_FLAG 2
`define B_TX_PACKET_READY 1
`define B_RX_PACKET_READY 0
// in endpoint control low bits
`define B_IN_STALL_SENT 5
`define B_IN_SEND_STALL 4
`define B_IN_UNDRUN 2
`define B_IN_FIFONE 1
`define B_IN_TX_READY 0
// in endpoint control high bits
`define B_TX_DOUBLE_BUFFER_EN 7
`define B_ISO 6
`define B_DIRECTION_SELECT 5
`define B_SPLIT 2

`endif

// *** common/ep_ctrl_pkg.sv ***
/*
 * types carried between the endpoint control registers and the serial engine.
 * assumes the engine runs on the same clock.
 */
package ep_ctrl_pkg;
   typedef struct packed {
      logic ep0_evt;
      logic [3:1] in_evt;
      logic [3:1] out_evt;
      logic [3:0] cm_evt;          // frame, bus reset, resume, suspend
      logic ep0_rx_pkt;
      logic [6:0] ep0_rx_bytes;
      logic ep0_setup_end;
      logic ep0_stall_sent;
      logic ep0_tx_done;
      logic ep0_data_end_done;
      logic [3:1] in_stall_sent;
      logic [3:1] in_underrun;
      logic [3:1] in_tx_done;
      logic [3:1] in_fifo_not_empty;
   } engine_evt_t;

   typedef struct packed {
      logic [3:1] ep_enable;
      logic [3:1] in_stall;
      logic [3:1] iso;
      logic [3:1] dir_in;
      logic [3:1] split;
      logic [3:1] tx_double_buf;
      logic [3:1] in_tx_ready;
      logic ep0_stall;
      logic ep0_tx_ready;
      logic ep0_data_end;
      logic ep0_rx_ready;
   } engine_ctrl_t;

   typedef struct packed {
      logic [7:0] index;
      logic [7:0] data;
   } rd_word_t;
endpackage

// *** hdl/rd_skid_buffer.sv ***
/*
 * two-entry buffer for read answers with valid/ready on both sides.
 * assumes the source holds nothing when in_ready_r is low.
 */
`timescale 1ns/1ps
module rd_skid_buffer (
   input wire logic clock,
   input wire logic reset,
   input wire logic in_valid,
   input ep_ctrl_pkg::rd_word_t in_word,
   output logic in_ready_r,
   output logic out_valid_r,
   output ep_ctrl_pkg::rd_word_t out_word_r,
   input wire logic out_ready
);
   import ep_ctrl_pkg::*;

   rd_word_t skid_r;
   logic skid_valid_r;
   logic take;
   logic drain;

   assign take = in_valid && in_ready_r;
   assign drain = out_valid_r && out_ready;

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         out_valid_r <= 1'b0;
         out_word_r <= '0;
         skid_valid_r <= 1'b0;
         skid_r <= '0;
         in_ready_r <= 1'b1;
      end else begin
         if (!out_valid_r || drain) begin
            out_valid_r <= skid_valid_r || take;
            out_word_r <= skid_valid_r ? skid_r : in_word;
            skid_valid_r <= skid_valid_r && take;
            if (skid_valid_r && take) begin
               skid_r <= in_word;
            end
            in_ready_r <= 1'b1;
         end else if (take) begin
            // output stalled: park word in second entry
            skid_r <= in_word;
            skid_valid_r <= 1'b1;
            in_ready_r <= 1'b0;
         end
      end
   end
endmodule // rd_skid_buffer

// *** hdl/ep_ctrl_regs.sv ***
/*
 * endpoint control and status registers of a full/low speed usb function,
 * reached through an index register and a data register.
 * assumes the serial engine on the same clock delivers one-cycle events.
 * read answers leave through a two-entry buffer so a stalled reader loses none.
 * firmware is expected to write the index before each data access.
 */
`timescale 1ns/1ps
`include "ep_ctrl_regs.svh"
module ep_ctrl_regs (
   input wire logic clock,
   input wire logic reset,
   input wire logic index_wr,
   input wire logic data_wr,
   input wire logic data_rd,
   input wire logic [7:0] wdata,
   output logic rd_accept_r,
   output logic rd_valid_r,
   output ep_ctrl_pkg::rd_word_t rd_word_r,
   input wire logic rd_ready,
   input ep_ctrl_pkg::engine_evt_t evt,
   output ep_ctrl_pkg::engine_ctrl_t ctrl_r,
   output logic irq_r
);
   import ep_ctrl_pkg::*;

   logic [7:0] indirect_index_reg_r;
   logic [1:0] ep_sel_r;
   logic [3:0] in_ie_r;
   logic [3:1] out_ie_r;
   logic [3:0] cm_ie_r;
   logic [7:0] ep_enable_r;
   logic [3:0] in_flags_r;
   logic [3:1] out_flags_r;
   logic [3:0] cm_flags_r;
   logic setup_end_flag_r;
   logic rx_packet_ready_r;
   logic ep0_send_stall_r;
   logic ep0_stall_sent_r;
   logic ep0_tx_ready_r;
   logic control_data_end_r;
   logic [6:0] ep0_rx_count_r;
   logic [3:1] stall_sent_r;
   logic [3:1] send_stall_r;
   logic [3:1] underrun_r;
   logic [3:1] tx_ready_r;
   logic [7:0] csr_high_r [1:3];
   logic rd_take;
   logic [7:0] rd_data;
   rd_word_t rd_in;

   function automatic logic hit(input logic [7:0] idx, input logic [7:0] target);
      hit = (idx == target);
   endfunction

   function automatic logic in_ep_hit(input logic [7:0] idx, input logic [1:0] sel,
                                      input logic [7:0] target);
      in_ep_hit = (idx == target) && (sel != 2'h0);
   endfunction

   function automatic logic sel_is(input logic [1:0] sel, input int ep);
      sel_is = (sel == 2'(ep));
   endfunction

   logic wr_in_ie, wr_out_ie, wr_cm_ie, wr_sel, wr_low, wr_high, wr_en, wr_e0;
   assign wr_in_ie = data_wr && hit(indirect_index_reg_r, `IDX_IN_IE);
   assign wr_out_ie = data_wr && hit(indirect_index_reg_r, `IDX_OUT_IE);
   assign wr_cm_ie = data_wr && hit(indirect_index_reg_r, `IDX_CM_IE);
   assign wr_sel = data_wr && hit(indirect_index_reg_r, `IDX_EP_SEL);
   assign wr_en = data_wr && hit(indirect_index_reg_r, `IDX_EP_ENABLE);
   assign wr_e0 = data_wr && hit(indirect_index_reg_r, `IDX_CSR_LOW) && sel_is(ep_sel_r, 0);
   assign wr_low = data_wr && in_ep_hit(indirect_index_reg_r, ep_sel_r, `IDX_CSR_LOW);
   assign wr_high = data_wr && in_ep_hit(indirect_index_reg_r, ep_sel_r, `IDX_CSR_HIGH);
   assign rd_take = data_rd && rd_accept_r;

   // per-endpoint strobes of the in endpoint control registers
   logic [3:1] low_wr;
   logic [3:1] high_wr;

   always_comb begin
      for (int i = 1; i <= 3; i++) begin
         low_wr[i] = wr_low && sel_is(ep_sel_r, i);
         high_wr[i] = wr_high && sel_is(ep_sel_r, i);
      end
   end

   // indirect index register
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         indirect_index_reg_r <= 8'h00;
         ep_sel_r <= 2'h0;
      end else begin
         if (index_wr) begin
            indirect_index_reg_r <= wdata;
         end
         if (wr_sel) begin
            ep_sel_r <= wdata[1:0];
         end
      end
   end

   // interrupt enables
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         in_ie_r <= `RST_IN_IE;
         out_ie_r <= `RST_OUT_IE;
         cm_ie_r <= `RST_CM_IE;
      end else begin
         if (wr_in_ie) begin
            in_ie_r <= wdata[3:0];
         end
         if (wr_out_ie) begin
            out_ie_r <= wdata[3:1];
         end
         if (wr_cm_ie) begin
            cm_ie_r <= wdata[3:0];
         end
      end
   end

   // endpoint enables
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         ep_enable_r <= `RST_EP_ENABLE;
      end else if (wr_en) begin
         ep_enable_r <= (ep_enable_r & ~`MASK_EP_ENABLE) | (wdata & `MASK_EP_ENABLE);
      end
   end

   // interrupt flags: cleared by the read that returns them, set wins
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         in_flags_r <= 4'h0;
      end else if (rd_take && hit(indirect_index_reg_r, `IDX_IN_FLAGS)) begin
         in_flags_r <= {evt.in_evt, evt.ep0_evt};
      end else begin
         in_flags_r <= in_flags_r | {evt.in_evt, evt.ep0_evt};
      end
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         out_flags_r <= 3'h0;
      end else if (rd_take && hit(indirect_index_reg_r, `IDX_OUT_FLAGS)) begin
         out_flags_r <= evt.out_evt;
      end else begin
         out_flags_r <= out_flags_r | evt.out_evt;
      end
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         cm_flags_r <= 4'h0;
      end else if (rd_take && hit(indirect_index_reg_r, `IDX_CM_FLAGS)) begin
         cm_flags_r <= evt.cm_evt;
      end else begin
         cm_flags_r <= cm_flags_r | evt.cm_evt;
      end
   end

   // endpoint 0 control and status
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         setup_end_flag_r <= 1'b0;
         rx_packet_ready_r <= 1'b0;
         ep0_send_stall_r <= 1'b0;
         ep0_stall_sent_r <= 1'b0;
         ep0_tx_ready_r <= 1'b0;
         control_data_end_r <= 1'b0;
      end else begin
         setup_end_flag_r <= evt.ep0_setup_end
            || (setup_end_flag_r && !(wr_e0 && wdata[`B_SERVICED_SETUP_END]));
         rx_packet_ready_r <= evt.ep0_rx_pkt
            || (rx_packet_ready_r && !(wr_e0 && wdata[`B_SERVICED_RX_PACKET]));
         ep0_stall_sent_r <= evt.ep0_stall_sent
            || (ep0_stall_sent_r && !(wr_e0 && !wdata[`B_STALL_SENT_FLAG]));
         if (wr_e0) begin
            ep0_send_stall_r <= wdata[`B_SEND_STALL];
         end
         if (wr_e0 && wdata[`B_TX_PACKET_READY]) begin
            ep0_tx_ready_r <= 1'b1;
         end else if (evt.ep0_tx_done) begin
            ep0_tx_ready_r <= 1'b0;
         end
         if (wr_e0 && wdata[`B_CONTROL_DATA_END]) begin
            control_data_end_r <= 1'b1;
         end else if (evt.ep0_data_end_done) begin
            control_data_end_r <= 1'b0;
         end
      end
   end

   // endpoint 0 received byte count, latched with the packet flag
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         ep0_rx_count_r <= 7'h00;
      end else if (evt.ep0_rx_pkt) begin
         ep0_rx_count_r <= evt.ep0_rx_bytes;
      end
   end

   // in endpoint control, one slot per endpoint 1..3
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         stall_sent_r <= 3'h0;
         send_stall_r <= 3'h0;
         underrun_r <= 3'h0;
         tx_ready_r <= 3'h0;
         for (int i = 1; i <= 3; i++) begin
            csr_high_r[i] <= 8'h00;
         end
      end else begin
         for (int i = 1; i <= 3; i++) begin
            stall_sent_r[i] <= evt.in_stall_sent[i]
               || (stall_sent_r[i] && !(low_wr[i] && !wdata[`B_IN_STALL_SENT]));
            underrun_r[i] <= evt.in_underrun[i]
               || (underrun_r[i] && !(low_wr[i] && !wdata[`B_IN_UNDRUN]));
            if (low_wr[i]) begin
               send_stall_r[i] <= wdata[`B_IN_SEND_STALL];
            end
            // a sent stall flushes the fifo, so the packet is gone
            if (low_wr[i] && wdata[`B_IN_TX_READY]) begin
               tx_ready_r[i] <= 1'b1;
            end else if (evt.in_tx_done[i] || evt.in_stall_sent[i]) begin
               tx_ready_r[i] <= 1'b0;
            end
            if (high_wr[i]) begin
               csr_high_r[i] <= wdata & `MASK_CSR_HIGH;
            end
         end
      end
   end

   // register to the engine
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         ctrl_r <= '0;
      end else begin
         ctrl_r.ep_enable <= ep_enable_r[3:1];
         for (int i = 1; i <= 3; i++) begin
            ctrl_r.in_stall[i] <= send_stall_r[i] && !csr_high_r[i][`B_ISO];
            ctrl_r.iso[i] <= csr_high_r[i][`B_ISO];
            ctrl_r.split[i] <= csr_high_r[i][`B_SPLIT];
            ctrl_r.dir_in[i] <= csr_high_r[i][`B_DIRECTION_SELECT]
               && !csr_high_r[i][`B_SPLIT];
            ctrl_r.tx_double_buf[i] <= csr_high_r[i][`B_TX_DOUBLE_BUFFER_EN];
         end
         ctrl_r.in_tx_ready <= tx_ready_r;
         ctrl_r.ep0_stall <= ep0_send_stall_r;
         ctrl_r.ep0_tx_ready <= ep0_tx_ready_r;
         ctrl_r.ep0_data_end <= control_data_end_r;
         ctrl_r.ep0_rx_ready <= rx_packet_ready_r;
      end
   end

   // single interrupt request
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <= |(in_flags_r & in_ie_r) || |(out_flags_r & out_ie_r)
            || |(cm_flags_r & cm_ie_r);
      end
   end

   // read mux
   always_comb begin
      rd_data = 8'h00;
      unique case (indirect_index_reg_r)
         `IDX_IN_FLAGS: rd_data = {4'h0, in_flags_r};
         `IDX_OUT_FLAGS: rd_data = {4'h0, out_flags_r, 1'b0};
         `IDX_CM_FLAGS: rd_data = {4'h0, cm_flags_r};
         `IDX_IN_IE: rd_data = {4'h0, in_ie_r};
         `IDX_OUT_IE: rd_data = {4'h0, out_ie_r, 1'b0};
         `IDX_CM_IE: rd_data = {4'h0, cm_ie_r};
         `IDX_EP_SEL: rd_data = {6'h00, ep_sel_r};
         `IDX_E0_COUNT: rd_data = (ep_sel_r == 2'h0) ? {1'b0, ep0_rx_count_r} : 8'h00;
         `IDX_EP_ENABLE: rd_data = ep_enable_r;
         `IDX_CSR_HIGH: rd_data = (ep_sel_r == 2'h0) ? 8'h00 : csr_high_r[ep_sel_r];
         `IDX_CSR_LOW: begin
            if (ep_sel_r == 2'h0) begin
               rd_data = {2'b00, ep0_send_stall_r, setup_end_flag_r, control_data_end_r,
                          ep0_stall_sent_r, ep0_tx_ready_r, rx_packet_ready_r};
            end else begin
               rd_data = {2'b00, stall_sent_r[ep_sel_r], send_stall_r[ep_sel_r], 1'b0,
                          underrun_r[ep_sel_r], evt.in_fifo_not_empty[ep_sel_r],
                          tx_ready_r[ep_sel_r]};
            end
         end
         default: rd_data = 8'h00;
      endcase
   end

   assign rd_in.index = indirect_index_reg_r;
   assign rd_in.data = rd_data;

   rd_skid_buffer u_rd_buf (
      .clock(clock),
      .reset(reset),
      .in_valid(data_rd),
      .in_word(rd_in),
      .in_ready_r(rd_accept_r),
      .out_valid_r(rd_valid_r),
      .out_word_r(rd_word_r),
      .out_ready(rd_ready)
   );
endmodule // ep_ctrl_regs

// *** bench/ep_ctrl_regs_assertions.sv ***
/* port assertions of the endpoint control registers.
   assumes one clock and index-then-data access. */
`timescale 1ns/1ps
`include "ep_ctrl_regs.svh"
module ep_ctrl_regs_checker (
   input wire logic clock,
   input wire logic reset,
   input wire logic index_wr,
   input wire logic data_wr,
   input wire logic data_rd,
   input wire logic [7:0] wdata,
   input wire logic rd_accept_r,
   input wire logic rd_valid_r,
   input ep_ctrl_pkg::rd_word_t rd_word_r,
   input wire logic rd_ready,
   input ep_ctrl_pkg::engine_evt_t evt,
   input ep_ctrl_pkg::engine_ctrl_t ctrl_r,
   input wire logic irq_r
);
   import ep_ctrl_pkg::*;
   logic [7:0] idx_r;
   logic [3:0] cm_ie_r;
   logic [3:1] en_r;
   logic [1:0] sel_r;
   default clocking @(posedge clock); endclocking
   default disable iff (reset);
   // shadow of firmware writes
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         idx_r <= 8'h00;
         cm_ie_r <= `RST_CM_IE;
         en_r <= 3'h7;
         sel_r <= 2'h0;
      end else begin
         if (index_wr) idx_r <= wdata;
         if (data_wr && idx_r == `IDX_CM_IE) cm_ie_r <= wdata[3:0];
         if (data_wr && idx_r == `IDX_EP_ENABLE) en_r <= wdata[3:1];
         if (data_wr && idx_r == `IDX_EP_SEL) sel_r <= wdata[1:0];
      end
   end
   a_answer_next: assert property (data_rd && rd_accept_r && !rd_valid_r |=> rd_valid_r)
      else $error("read answer late");
   a_answer_index: assert property (data_rd && rd_accept_r && !rd_valid_r |=>
      rd_word_r.index == $past(idx_r)) else $error("read answer has wrong index");
   a_answer_holds: assert property (rd_valid_r && !rd_ready |=>
      rd_valid_r && $stable(rd_word_r)) else $error("read answer not held");
   a_accept_empty: assert property (!rd_valid_r |-> rd_accept_r)
      else $error("empty buffer refuses reads");
   a_enable_follow: assert property (!$past(reset) |-> ctrl_r.ep_enable == $past(en_r))
      else $error("endpoint enable not passed on");
   a_reset_irq: assert property (evt.cm_evt[2] && cm_ie_r[2] && !data_wr |-> ##2 irq_r)
      else $error("bus reset event gave no interrupt");
   a_stall_not_iso: assert property ((ctrl_r.in_stall & ctrl_r.iso) == 3'h0)
      else $error("stall on isochronous endpoint");
   a_dir_split: assert property ((ctrl_r.dir_in & ctrl_r.split) == 3'h0)
      else $error("direction used on split fifo");
   a_rx_ready_set: assert property (evt.ep0_rx_pkt |-> ##2 ctrl_r.ep0_rx_ready)
      else $error("received packet not flagged");
   a_serviced_clear: assert property (data_wr && idx_r == `IDX_CSR_LOW && sel_r == 2'h0
      && wdata[`B_SERVICED_RX_PACKET] && !evt.ep0_rx_pkt |-> ##2 !ctrl_r.ep0_rx_ready)
      else $error("serviced packet write did not clear");
endmodule // ep_ctrl_regs_checker
bind ep_ctrl_regs ep_ctrl_regs_checker i_ep_ctrl_regs_checker (.clock(clock), .reset(reset),
   .index_wr(index_wr), .data_wr(data_wr), .data_rd(data_rd), .wdata(wdata),
   .rd_accept_r(rd_accept_r), .rd_valid_r(rd_valid_r), .rd_word_r(rd_word_r),
   .rd_ready(rd_ready), .evt(evt), .ctrl_r(ctrl_r), .irq_r(irq_r));

// *** bench/usb_engine_model.sv ***
/* behavioural serial engine facing the endpoint registers.
   assumes fire is called just after a rising clock edge. */
`timescale 1ns/1ps
module usb_engine_model (
   input wire logic clock,
   input ep_ctrl_pkg::engine_ctrl_t ctrl,
   output ep_ctrl_pkg::engine_evt_t evt,
   output logic [3:1] stall_hs,
   output logic [3:1] silent
);
   import ep_ctrl_pkg::*;
   // in token answer: stall only if enabled and not isochronous
   assign stall_hs = ctrl.ep_enable & ctrl.in_stall & ~ctrl.iso;
   assign silent = ~ctrl.ep_enable;
   initial begin
      evt = '0;
   end
   // one-cycle event, byte count sent with the packet flag
   task fire(input engine_evt_t e);
      evt = e;
      @(posedge clock);
      #1;
      evt = '0;
   endtask
endmodule // usb_engine_model

// *** bench/ep_ctrl_regs_test.sv ***
/* self-checking bench of the endpoint control registers.
   assumes the engine model and the bound checker. */
`timescale 1ns/1ps
module ep_ctrl_regs_test;
   import ep_ctrl_pkg::*;
   logic clock = 0, reset = 1, index_wr = 0, data_wr = 0, data_rd = 0, rd_ready = 1;
   logic [7:0] wdata = 8'h00;
   logic rd_accept_r, rd_valid_r, irq_r;
   logic [3:1] stall_hs, silent;
   rd_word_t rd_word_r;
   engine_evt_t evt, e;
   engine_ctrl_t ctrl_r;
   int num_errors = 0, n_checks = 0;
   // write table: index, value, read back
   logic [7:0] wa [7] = '{8'h09, 8'h0b, 8'h0b, 8'h07, 8'h1e, 8'h1e, 8'h30};
   logic [7:0] wv [7] = '{8'hff, 8'hff, 8'h06, 8'hff, 8'h00, 8'h0f, 8'h55};
   logic [7:0] wr_back [7] = '{8'h0e, 8'h0f, 8'h06, 8'h0f, 8'h10, 8'h1f, 8'h00};
   // value each register holds before its write
   logic [7:0] wpre [7] = '{8'h0e, 8'h06, 8'h0f, 8'h0f, 8'h1f, 8'h10, 8'h00};
   // event table: enable index/value, event bit in struct, flag index/value, irq
   logic [7:0] iea [8] = '{8'h0b, 8'h0b, 8'h0b, 8'h09, 8'h09, 8'h07, 8'h07, 8'h07};
   logic [7:0] iev [8] = '{8'h06, 8'h06, 8'h07, 8'h0a, 8'h0e, 8'h0e, 8'h0d, 8'h0f};
   int evb [8] = '{26, 27, 24, 29, 28, 34, 31, 33};
   logic [7:0] fa [8] = '{8'h06, 8'h06, 8'h06, 8'h04, 8'h04, 8'h02, 8'h02, 8'h02};
   logic [7:0] fv [8] = '{8'h04, 8'h08, 8'h01, 8'h04, 8'h02, 8'h01, 8'h02, 8'h08};
   logic irq_x [8] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1};
   ep_ctrl_regs i_ep_ctrl_regs (.clock(clock), .reset(reset), .index_wr(index_wr),
      .data_wr(data_wr), .data_rd(data_rd), .wdata(wdata), .rd_accept_r(rd_accept_r),
      .rd_valid_r(rd_valid_r), .rd_word_r(rd_word_r), .rd_ready(rd_ready), .evt(evt),
      .ctrl_r(ctrl_r), .irq_r(irq_r));
   usb_engine_model i_usb_engine_model (.clock(clock), .ctrl(ctrl_r), .evt(evt),
      .stall_hs(stall_hs), .silent(silent));
   initial begin
      forever #2 clock = ~clock;
   end
   task conclude;
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task step;
      @(posedge clock);
      #1;
   endtask
   task hang;
      num_errors++;
      conclude;
   endtask
   task put_idx(input logic [7:0] a);
      index_wr = 1;
      wdata = a;
      step;
      index_wr = 0;
   endtask
   task wr(input logic [7:0] a, input logic [7:0] v);
      put_idx(a);
      data_wr = 1;
      wdata = v;
      step;
      data_wr = 0;
   endtask
   task ask(input logic [7:0] a);
      int n;
      n = 0;
      put_idx(a);
      while (rd_accept_r !== 1'b1 && n < 50) begin
         step;
         n++;
      end
      if (n == 50) hang;
      data_rd = 1;
      step;
      data_rd = 0;
   endtask
   task take(input logic [7:0] a, input logic [7:0] v);
      int n;
      n = 0;
      while (rd_valid_r !== 1'b1 && n < 50) begin
         step;
         n++;
      end
      if (n == 50) hang;
      check("read word", rd_word_r, {a, v});
      step;
   endtask
   task rd(input logic [7:0] a, input logic [7:0] v);
      ask(a);
      take(a, v);
   endtask
   initial begin
      repeat (12) @(posedge clock);
      #1;
      reset = 0;
      step;
      check("enables", ctrl_r.ep_enable, 3'h7);
      rd(8'h07, 8'h0f);
      rd(8'h12, 8'h00);
      for (int i = 0; i < 7; i++) begin
         rd(wa[i], wpre[i]);
         wr(wa[i], wv[i]);
         rd(wa[i], wr_back[i]);
      end
      for (int i = 0; i < 8; i++) begin
         wr(iea[i], iev[i]);
         e = '0;
         e[evb[i]] = 1'b1;
         i_usb_engine_model.fire(e);
         step;
         check("irq", irq_r, irq_x[i]);
         rd(fa[i], fv[i]);
         check("irq after read", irq_r, 1'b0);
         rd(fa[i], 8'h00);
      end
      // stalled consumer: fill, refused read, drain
      rd_ready = 0;
      e = '0;
      e.cm_evt[1] = 1'b1;
      i_usb_engine_model.fire(e);
      ask(8'h0b);
      ask(8'h1e);
      check("accept", rd_accept_r, 1'b0);
      put_idx(8'h06);
      data_rd = 1;
      step;
      data_rd = 0;
      rd_ready = 1;
      take(8'h0b, 8'h07);
      take(8'h1e, 8'h1f);
      rd(8'h06, 8'h02);
      wr(8'h0e, 8'h00);
      e = '0;
      e.ep0_rx_pkt = 1'b1;
      e.ep0_rx_bytes = 7'h7f;
      e.ep0_setup_end = 1'b1;
      i_usb_engine_model.fire(e);
      rd(8'h11, 8'h11);
      rd(8'h16, 8'h7f);
      wr(8'h11, 8'h80);
      rd(8'h11, 8'h01);
      wr(8'h11, 8'h00);
      rd(8'h11, 8'h01);
      wr(8'h11, 8'h40);
      rd(8'h11, 8'h00);
      check("rx ready", ctrl_r.ep0_rx_ready, 1'b0);
      wr(8'h11, 8'h2a);
      step;
      check("ep0", {ctrl_r.ep0_stall, ctrl_r.ep0_data_end, ctrl_r.ep0_tx_ready}, 3'h7);
      e = '0;
      e.ep0_stall_sent = 1'b1;
      e.ep0_tx_done = 1'b1;
      e.ep0_data_end_done = 1'b1;
      i_usb_engine_model.fire(e);
      rd(8'h11, 8'h24);
      wr(8'h11, 8'h04);
      rd(8'h11, 8'h04);
      wr(8'h11, 8'h00);
      rd(8'h11, 8'h00);
      for (int i = 1; i < 4; i++) begin
         wr(8'h0e, i[7:0]);
         wr(8'h11, 8'h10);
         step;
         check("stall", {ctrl_r.in_stall[i], stall_hs[i]}, 2'b11);
         wr(8'h12, 8'h40);
         step;
         check("iso", {ctrl_r.iso[i], ctrl_r.in_stall[i]}, 2'b10);
         wr(8'h12, 8'h20);
         step;
         check("dir", {ctrl_r.dir_in[i], ctrl_r.in_stall[i]}, 2'b11);
         wr(8'h12, 8'h24);
         rd(8'h12, 8'h24);
         check("split", {ctrl_r.dir_in[i], ctrl_r.split[i]}, 2'b01);
         wr(8'h12, 8'h80);
         wr(8'h11, 8'h01);
         step;
         check("dbuf", {ctrl_r.tx_double_buf[i], ctrl_r.in_tx_ready[i]}, 2'b11);
         e = '0;
         e.in_stall_sent[i] = 1'b1;
         e.in_underrun[i] = 1'b1;
         e.in_tx_done[i] = 1'b1;
         i_usb_engine_model.fire(e);
         rd(8'h11, 8'h24);
         wr(8'h11, 8'h00);
         wr(8'h1e, 8'h0f & ~(8'h01 << i));
         step;
         check("silent", {ctrl_r.in_stall[i], silent}, {1'b0, 3'b001 << (i - 1)});
         wr(8'h1e, 8'h0f);
      end
      conclude;
   end
endmodule // ep_ctrl_regs_test
